// *** src/mmd_pkg.sv ***
// Package for the memory map decoder of a small 8-bit core.
// Assumes one core clock, a synchronous reset and a core that retires
// at most one instruction per clock through the request struct.
package mmd_pkg;

    // ------------------------------------------------------------------
    // Widths and sizes
    // ------------------------------------------------------------------
    localparam int PC_W        = 10;
    localparam int PROG_WORDS  = 1024;
    localparam int INSTR_W     = 14;
    localparam int STACK_LVLS  = 8;
    localparam int SP_W        = 3;
    localparam int DEPTH_W     = 4;
    localparam int DATA_W      = 8;
    localparam int LOC_W       = 6;
    localparam int PAGE_AW     = 4;
    localparam int GPR_WORDS   = 48;

    // ------------------------------------------------------------------
    // Program space landmarks
    // ------------------------------------------------------------------
    localparam logic [PC_W-1:0]    RESET_VEC   = 10'h000;
    localparam logic [PC_W-1:0]    SWI_VEC     = 10'h001;
    localparam logic [PC_W-1:0]    HWI_VEC     = 10'h008;
    localparam logic [PC_W-1:0]    ROLL_ADDR0  = 10'h00e;
    localparam logic [PC_W-1:0]    ROLL_ADDR1  = 10'h00f;
    localparam logic [PC_W-1:0]    RSVD_FIRST  = 10'h3fe;
    localparam logic [PC_W-1:0]    PC_ONE      = 10'h001;
    // Preset rolling code words; the values are arbitrary.
    localparam logic [INSTR_W-1:0] ROLL_CODE0  = 14'h1234;
    localparam logic [INSTR_W-1:0] ROLL_CODE1  = 14'h0abc;

    // ------------------------------------------------------------------
    // Data space layout
    // ------------------------------------------------------------------
    localparam logic [LOC_W-1:0]   GPR_FIRST   = 6'h10;
    localparam int                 BANK_HI     = 7;
    localparam int                 BANK_LO     = 6;
    localparam int                 PCH_SJ_BIT  = 1;
    localparam logic [DEPTH_W-1:0] DEPTH_FULL  = 4'h8;
    localparam logic [DEPTH_W-1:0] DEPTH_ONE   = 4'h1;
    localparam logic [SP_W-1:0]    SP_ONE      = 3'h1;

    // Register-page offsets.
    localparam logic [PAGE_AW-1:0] R_INDIRECT  = 4'h0;
    localparam logic [PAGE_AW-1:0] R_TIMER0    = 4'h1;
    localparam logic [PAGE_AW-1:0] R_PC_LOW    = 4'h2;
    localparam logic [PAGE_AW-1:0] R_FLAGS     = 4'h3;
    localparam logic [PAGE_AW-1:0] R_FSP       = 4'h4;
    localparam logic [PAGE_AW-1:0] R_PORT_B    = 4'h6;
    localparam logic [PAGE_AW-1:0] R_PWR       = 4'h8;
    localparam logic [PAGE_AW-1:0] R_WAKE      = 4'h9;
    localparam logic [PAGE_AW-1:0] R_PC_HBUF   = 4'ha;
    localparam logic [PAGE_AW-1:0] R_PULL_LO   = 4'hb;
    localparam logic [PAGE_AW-1:0] R_PULL_HI   = 4'hc;
    localparam logic [PAGE_AW-1:0] R_INT_EN    = 4'he;
    localparam logic [PAGE_AW-1:0] R_INT_FLAG  = 4'hf;
    // One bit per implemented location; 5, 7 and 13 stay empty.
    localparam logic [15:0]        R_IMPL      = 16'hdf5f;
    // F-page holds 0x6, 0xa, 0xc, 0xf; S-page holds 0x0..0x8 and 0xf.
    localparam logic [15:0]        F_IMPL      = 16'h9440;
    localparam logic [15:0]        S_IMPL      = 16'h81ff;

    // Reset values of the register-page registers that have them.
    localparam logic [DATA_W-1:0]  RST_FLAGS   = 8'h18;
    localparam logic [DATA_W-1:0]  RST_PWR     = 8'h88;
    localparam logic [DATA_W-1:0]  RST_WAKE    = 8'h3f;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        FL_NEXT  = 4'h0,
        FL_SJMP  = 4'h1,
        FL_SCALL = 4'h3,
        FL_AJMP  = 4'h2,
        FL_ACALL = 4'h6,
        FL_LJMP  = 4'h7,
        FL_LONG_CALL_INSTR = 4'h5,
        FL_RET   = 4'h4,
        FL_RETL  = 4'hc,
        FL_RETI  = 4'hd,
        FL_SWI   = 4'hf,
        FL_HWI   = 4'he
    } mmd_flow_t;

    typedef enum logic [1:0] {
        SP_NONE = 2'h0,
        SP_R    = 2'h1,
        SP_S    = 2'h3,
        SP_F    = 2'h2
    } mmd_space_t;

    typedef struct packed {
        logic              step;
        mmd_flow_t         flow;
        logic [PC_W-1:0]   target;
        logic [DATA_W-1:0] acc;
        logic              dvalid;
        logic              dwrite;
        mmd_space_t        space;
        logic [LOC_W-1:0]  addr;
        logic [DATA_W-1:0] wdata;
    } mmd_core_req_t;

    typedef struct packed {
        logic [PC_W-1:0]    pc;
        logic [INSTR_W-1:0] instr;
        logic [DATA_W-1:0]  rdata;
        logic [1:0]         bank;
        logic [DEPTH_W-1:0] depth;
        logic               rsvd_fetch;
    } mmd_core_rsp_t;

    typedef struct packed {
        logic               we;
        logic [PC_W-1:0]    addr;
        logic [INSTR_W-1:0] data;
    } mmd_prog_t;

    typedef struct packed {
        logic [PC_W-1:0]                      pc;
        logic [INSTR_W-1:0]                   instr;
        logic [DATA_W-1:0]                    rdata;
        logic [1:0]                           bank;
        logic [15:0][DATA_W-1:0]              rpage;
        logic [15:0][DATA_W-1:0]              fpage;
        logic [15:0][DATA_W-1:0]              spage;
        logic [GPR_WORDS-1:0][DATA_W-1:0]     ram;
        logic [STACK_LVLS-1:0][PC_W-1:0]      stack;
        logic [SP_W-1:0]                      sp;
        logic [DEPTH_W-1:0]                   depth;
    } mmd_state_t;

    function automatic mmd_state_t mmd_reset_state();
        mmd_state_t s;
        s = '0;
        s.pc = RESET_VEC;
        s.rpage[R_FLAGS] = RST_FLAGS;
        s.rpage[R_PWR] = RST_PWR;
        s.rpage[R_WAKE] = RST_WAKE;
        return s;
    endfunction : mmd_reset_state

endpackage : mmd_pkg

// *** src/mmd_decoder.sv ***
// Program counter, return stack and data space decoder of an 8-bit core.
// Assumes the fetch and execute logic presents one request per clock and
// that requests are synchronous to CORE_CLK.
`timescale 1ns/1ps

module mmd_decoder
    import mmd_pkg::*;
(
    input  wire logic             CORE_CLK,
    input  wire logic             RST,
    input  mmd_pkg::mmd_core_req_t CORE_REQ,
    input  mmd_pkg::mmd_prog_t     PROG,
    input  wire logic             ROLL_RELEASE,
    output mmd_pkg::mmd_core_rsp_t CORE_RSP
);
    import mmd_pkg::*;

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    localparam mmd_state_t STATE_RST = mmd_reset_state();

    logic [INSTR_W-1:0]       prog_mem [PROG_WORDS];
    mmd_state_t               s_reg;
    mmd_state_t               s_next;
    logic                     indirect;
    logic [LOC_W-1:0]         loc;
    logic [PAGE_AW-1:0]       sfr_idx;
    logic [PAGE_AW-1:0]       page_idx;
    logic [LOC_W-1:0]         gpr_idx;
    logic                     is_sfr;
    logic [DATA_W-1:0]        rd_val;
    logic                     wr_en;
    logic [PC_W-1:0]          pc_inc;
    logic [PC_W-1:0]          pc_new;
    logic                     do_push;
    logic                     do_pop;
    logic                     pcl_write;
    logic [1:0]               pch;

    // The program array is loaded through the programming port only; the
    // core never writes it, so it carries no reset.
    always_ff @(posedge CORE_CLK)
    begin
        if (PROG.we)
        begin
            prog_mem[PROG.addr] <= PROG.data;
        end
    end

    // ------------------------------------------------------------------
    // Data space address decode
    // ------------------------------------------------------------------
    // The bank field steers no page; every bank folds back
    // onto bank 0, so it is reported but does not change the location.
    always_comb
    begin
        indirect = (CORE_REQ.space == SP_R) && (CORE_REQ.addr == {2'h0, R_INDIRECT});
        loc      = indirect ? s_reg.rpage[R_FSP][LOC_W-1:0] : CORE_REQ.addr;
        is_sfr   = loc < GPR_FIRST;
        sfr_idx  = loc[PAGE_AW-1:0];
        gpr_idx  = loc - GPR_FIRST;
        page_idx = CORE_REQ.addr[PAGE_AW-1:0];
        rd_val   = '0;
        if (CORE_REQ.space == SP_R)
        begin
            if (!is_sfr)
            begin
                rd_val = s_reg.ram[gpr_idx[5:0]];
            end
            else if (!R_IMPL[sfr_idx])
            begin
                rd_val = '0;
            end
            else if (sfr_idx == R_INDIRECT)
            begin
                // Pointing the port at itself yields zero, not a loop.
                rd_val = '0;
            end
            else if (sfr_idx == R_PC_LOW)
            begin
                rd_val = s_reg.pc[DATA_W-1:0];
            end
            else
            begin
                rd_val = s_reg.rpage[sfr_idx];
            end
        end
        else if (CORE_REQ.space == SP_F)
        begin
            rd_val = F_IMPL[page_idx] ? s_reg.fpage[page_idx] : '0;
        end
        else if (CORE_REQ.space == SP_S)
        begin
            rd_val = S_IMPL[page_idx] ? s_reg.spage[page_idx] : '0;
        end
        else
        begin
            rd_val = '0;
        end
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        s_next    = s_reg;
        wr_en     = CORE_REQ.dvalid && CORE_REQ.dwrite;
        pcl_write = wr_en && (CORE_REQ.space == SP_R) && is_sfr && (sfr_idx == R_PC_LOW);
        pch       = s_reg.rpage[R_PC_HBUF][1:0];
        pc_inc    = s_reg.pc + PC_ONE;
        pc_new    = pc_inc;
        do_push   = 1'b0;
        do_pop    = 1'b0;

        // Data reads are captured so the data output comes from a flop.
        if (CORE_REQ.dvalid && !CORE_REQ.dwrite)
        begin
            s_next.rdata = rd_val;
            s_next.bank  = s_reg.rpage[R_FSP][BANK_HI:BANK_LO];
        end

        // Writes land only on implemented locations of the addressed page.
        if (wr_en && (CORE_REQ.space == SP_R))
        begin
            if (!is_sfr)
            begin
                s_next.ram[gpr_idx[5:0]] = CORE_REQ.wdata;
            end
            else if (R_IMPL[sfr_idx] && (sfr_idx != R_INDIRECT) && (sfr_idx != R_PC_LOW))
            begin
                s_next.rpage[sfr_idx] = CORE_REQ.wdata;
            end
        end
        else if (wr_en && (CORE_REQ.space == SP_F) && F_IMPL[page_idx])
        begin
            s_next.fpage[page_idx] = CORE_REQ.wdata;
        end
        else if (wr_en && (CORE_REQ.space == SP_S) && S_IMPL[page_idx])
        begin
            s_next.spage[page_idx] = CORE_REQ.wdata;
        end

        // Program flow for a retired instruction.
        if (CORE_REQ.step)
        begin
            case (CORE_REQ.flow)
                FL_SJMP:  pc_new = {pch[PCH_SJ_BIT], CORE_REQ.target[8:0]};
                FL_SCALL:
                begin
                    pc_new  = {pch, CORE_REQ.target[7:0]};
                    do_push = 1'b1;
                end
                FL_AJMP:  pc_new = {pch, CORE_REQ.acc};
                FL_ACALL:
                begin
                    pc_new  = {pch, CORE_REQ.acc};
                    do_push = 1'b1;
                end
                FL_LJMP:  pc_new = CORE_REQ.target;
                FL_LONG_CALL_INSTR:
                begin
                    pc_new  = CORE_REQ.target;
                    do_push = 1'b1;
                end
                FL_RET, FL_RETL, FL_RETI:
                begin
                    pc_new = s_reg.stack[s_reg.sp - SP_ONE];
                    do_pop = 1'b1;
                end
                FL_SWI:
                begin
                    pc_new  = SWI_VEC;
                    do_push = 1'b1;
                end
                FL_HWI:
                begin
                    pc_new  = HWI_VEC;
                    do_push = 1'b1;
                end
                default:
                begin
                    // A write to the low counter byte acts as a computed jump.
                    pc_new = pcl_write ? {pch, CORE_REQ.wdata} : pc_inc;
                end
            endcase
            s_next.pc = pc_new;
        end

        // The stack is circular: a ninth push overwrites the oldest entry,
        // and the depth count saturates so software can see overflow.
        if (do_push)
        begin
            s_next.stack[s_reg.sp] = pc_inc;
            s_next.sp              = s_reg.sp + SP_ONE;
            if (s_reg.depth != DEPTH_FULL)
            begin
                s_next.depth = s_reg.depth + DEPTH_ONE;
            end
        end
        else if (do_pop)
        begin
            s_next.sp = s_reg.sp - SP_ONE;
            if (s_reg.depth != '0)
            begin
                s_next.depth = s_reg.depth - DEPTH_ONE;
            end
        end

        // Fetch word follows the new counter; the rolling code words
        // shadow the array until they are released.
        if (!ROLL_RELEASE && (s_next.pc == ROLL_ADDR0))
        begin
            s_next.instr = ROLL_CODE0;
        end
        else if (!ROLL_RELEASE && (s_next.pc == ROLL_ADDR1))
        begin
            s_next.instr = ROLL_CODE1;
        end
        else
        begin
            s_next.instr = prog_mem[s_next.pc];
        end
    end

    // Single state register; reset loads only constants.
    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
        begin
            s_reg <= STATE_RST;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from the state flops.
    assign CORE_RSP.pc         = s_reg.pc;
    assign CORE_RSP.instr      = s_reg.instr;
    assign CORE_RSP.rdata      = s_reg.rdata;
    assign CORE_RSP.bank       = s_reg.bank;
    assign CORE_RSP.depth      = s_reg.depth;
    // Flags a fetch from the two top words, which software must avoid.
    assign CORE_RSP.rsvd_fetch = s_reg.pc >= RSVD_FIRST;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    // All checks run on the core clock; all but reset_vector_a rest while reset is held.
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);

    reset_vector_a: assert property (disable iff (1'b0) RST |=> (s_reg.pc == RESET_VEC))
        else $error("Counter not at zero after reset.");
    soft_vector_a: assert property (CORE_REQ.step && CORE_REQ.flow == FL_SWI
        |=> s_reg.pc == SWI_VEC && s_reg.stack[$past(s_reg.sp)] == $past(pc_inc))
        else $error("Software interrupt entry or push wrong.");
    hard_vector_a: assert property (CORE_REQ.step && CORE_REQ.flow == FL_HWI
        |=> s_reg.pc == HWI_VEC)
        else $error("Hardware interrupt entry wrong.");
    short_call_a: assert property (CORE_REQ.step && CORE_REQ.flow == FL_SCALL
        |=> s_reg.pc == {$past(pch), $past(CORE_REQ.target[7:0])})
        else $error("Short call target wrong.");
    short_jump_a: assert property (CORE_REQ.step && CORE_REQ.flow == FL_SJMP
        |=> s_reg.pc == {$past(pch[PCH_SJ_BIT]), $past(CORE_REQ.target[8:0])})
        else $error("Short jump target wrong.");
    long_jump_a: assert property (CORE_REQ.step && CORE_REQ.flow == FL_LJMP
        |=> s_reg.pc == $past(CORE_REQ.target))
        else $error("Long jump target wrong.");
    call_return_a: assert property (CORE_REQ.step && CORE_REQ.flow == FL_LONG_CALL_INSTR
        ##1 CORE_REQ.step && CORE_REQ.flow == FL_RET
        |=> s_reg.pc == PC_W'($past(s_reg.pc, 2) + PC_ONE))
        else $error("Return did not restore the address after the call.");
    stack_depth_a: assert property (s_reg.depth <= DEPTH_FULL)
        else $error("Stack depth above eight.");
    empty_read_a: assert property (CORE_REQ.dvalid && !CORE_REQ.dwrite
        && CORE_REQ.space == SP_F && !F_IMPL[CORE_REQ.addr[3:0]] |=> s_reg.rdata == '0)
        else $error("Empty F-page location did not read zero.");
    mirror_read_a: assert property (CORE_REQ.dvalid && !CORE_REQ.dwrite
        && CORE_REQ.space == SP_R && !indirect && CORE_REQ.addr >= GPR_FIRST
        |=> s_reg.rdata == $past(s_reg.ram[CORE_REQ.addr - GPR_FIRST]))
        else $error("General SRAM read not mapped onto bank 0.");

    // Counter steps, computed and accumulator jumps.
    pc_step_a: assert property (CORE_REQ.step && CORE_REQ.flow == FL_NEXT && !pcl_write
        |=> s_reg.pc == PC_W'($past(s_reg.pc) + PC_ONE))
        else $error("Counter did not step by one.");
    pcl_jump_a: assert property (CORE_REQ.step && CORE_REQ.flow == FL_NEXT && pcl_write
        |=> s_reg.pc == {$past(pch), $past(CORE_REQ.wdata)})
        else $error("Low counter byte write did not jump.");
    acc_jump_a: assert property (CORE_REQ.step && (CORE_REQ.flow == FL_AJMP || CORE_REQ.flow == FL_ACALL)
        |=> s_reg.pc == {$past(pch), $past(CORE_REQ.acc)})
        else $error("Accumulator jump target wrong.");

    // Long calls jump and push the next address; pushes grow and pops shrink the saturating depth.
    long_call_a: assert property (CORE_REQ.step && CORE_REQ.flow == FL_LONG_CALL_INSTR
        |=> s_reg.pc == $past(CORE_REQ.target) && s_reg.stack[$past(s_reg.sp)] == $past(pc_inc))
        else $error("Long call target or pushed address wrong.");
    push_depth_a: assert property (do_push && s_reg.depth != DEPTH_FULL
        |=> s_reg.depth == DEPTH_W'($past(s_reg.depth) + DEPTH_ONE))
        else $error("Stack depth did not grow on a push.");
    pop_depth_a: assert property (do_pop && s_reg.depth != '0
        |=> s_reg.depth == DEPTH_W'($past(s_reg.depth) - DEPTH_ONE))
        else $error("Stack depth did not shrink on a pop.");

    // Reads capture the bank; indirect writes follow the pointer.
    bank_capture_a: assert property (CORE_REQ.dvalid && !CORE_REQ.dwrite
        |=> s_reg.bank == $past(s_reg.rpage[R_FSP][BANK_HI:BANK_LO]))
        else $error("Bank field not captured with the read.");
    indir_write_a: assert property (CORE_REQ.dvalid && CORE_REQ.dwrite && indirect && !is_sfr
        |=> s_reg.ram[$past(s_reg.rpage[R_FSP][LOC_W-1:0]) - GPR_FIRST] == $past(CORE_REQ.wdata))
        else $error("Indirect write missed the pointed location.");

    // A write in one page must leave the other two untouched.
    rpage_only_a: assert property (CORE_REQ.dvalid && CORE_REQ.dwrite && CORE_REQ.space == SP_R
        |=> s_reg.fpage == $past(s_reg.fpage) && s_reg.spage == $past(s_reg.spage))
        else $error("Register page write reached another page.");
    fpage_only_a: assert property (CORE_REQ.dvalid && CORE_REQ.dwrite && CORE_REQ.space == SP_F
        |=> s_reg.rpage == $past(s_reg.rpage) && s_reg.ram == $past(s_reg.ram) && s_reg.spage == $past(s_reg.spage))
        else $error("F-page write reached another page.");
    spage_only_a: assert property (CORE_REQ.dvalid && CORE_REQ.dwrite && CORE_REQ.space == SP_S
        |=> s_reg.rpage == $past(s_reg.rpage) && s_reg.ram == $past(s_reg.ram) && s_reg.fpage == $past(s_reg.fpage))
        else $error("S-page write reached another page.");

    // Empty locations read zero; the first preset word shadows the array.
    reg_empty_a: assert property (CORE_REQ.dvalid && !CORE_REQ.dwrite && CORE_REQ.space == SP_R
        && is_sfr && !R_IMPL[sfr_idx] |=> s_reg.rdata == '0)
        else $error("Empty register page location did not read zero.");
    spage_empty_a: assert property (CORE_REQ.dvalid && !CORE_REQ.dwrite && CORE_REQ.space == SP_S
        && !S_IMPL[CORE_REQ.addr[PAGE_AW-1:0]] |=> s_reg.rdata == '0)
        else $error("Empty S-page location did not read zero.");
    roll_code_a: assert property (!ROLL_RELEASE && s_next.pc == ROLL_ADDR0
        |=> s_reg.instr == ROLL_CODE0)
        else $error("Preset rolling code word not fetched.");

    swi_seen_c: cover property (CORE_REQ.step && CORE_REQ.flow == FL_SWI);
    nest_hwi_c: cover property (CORE_REQ.step && CORE_REQ.flow == FL_HWI && s_reg.depth == DEPTH_ONE);
    indir_rd_c: cover property (indirect && CORE_REQ.dvalid && !CORE_REQ.dwrite && !is_sfr);
    full_stk_c: cover property (s_reg.depth == DEPTH_FULL);
    back_ret_c: cover property (CORE_REQ.step && CORE_REQ.flow == FL_LONG_CALL_INSTR ##1 CORE_REQ.step && CORE_REQ.flow == FL_RET);

endmodule : mmd_decoder

// *** verif/mmd_core_model.sv ***
// Behavioural model of the core fetch and execute logic for the decoder.
// Assumes the bench calls its tasks from one process; it drives on falling edges.
`timescale 1ns/1ps

module mmd_core_model
    import mmd_pkg::*;
(
    input  wire logic              CORE_CLK,
    output mmd_pkg::mmd_core_req_t CORE_REQ,
    output mmd_pkg::mmd_prog_t     PROG
);
    import mmd_pkg::*;

    // Idle addr, wdata and program data lines carry inverted old values so stale data never passes for new.
    initial
    begin
        CORE_REQ = '0;
        PROG     = '0;
    end

    // One request for one taking edge, then the request is withdrawn.
    task automatic issue(input mmd_core_req_t r);
        @(negedge CORE_CLK);
        CORE_REQ = r;
        @(negedge CORE_CLK);
        CORE_REQ.step   = 1'b0;
        CORE_REQ.dvalid = 1'b0;
        CORE_REQ.addr   = ~CORE_REQ.addr;
        CORE_REQ.wdata  = ~CORE_REQ.wdata;
    endtask : issue

    // Two requests on consecutive taking edges, then withdrawn.
    task automatic issue2(input mmd_core_req_t r1, input mmd_core_req_t r2);
        @(negedge CORE_CLK);
        CORE_REQ = r1;
        issue(r2);
    endtask : issue2

    // Code is never placed in the top two reserved words.
    task automatic load(input logic [PC_W-1:0] a, input logic [INSTR_W-1:0] d);
        if (a < RSVD_FIRST)
        begin
            @(negedge CORE_CLK);
            PROG = '{we: 1'b1, addr: a, data: d};
            @(negedge CORE_CLK);
            PROG.we   = 1'b0;
            PROG.data = ~PROG.data;
        end
    endtask : load
endmodule : mmd_core_model

// *** verif/mmd_decoder_tb_top.sv ***
// Self-checking bench for the memory map decoder.
// Assumes the core model drives requests; rows hold expected responses.
`timescale 1ns/1ps

module mmd_decoder_tb_top;
    import mmd_pkg::*;

    typedef struct packed {
        mmd_core_req_t      req;
        logic [PC_W-1:0]    pc;
        logic [DATA_W-1:0]  rd;
        logic [1:0]         bk;
        logic [DEPTH_W-1:0] dep;
    } mmd_row_t;

    logic          core_clk     = 1'b0;
    logic          rst          = 1'b1;
    logic          roll_release = 1'b0;
    mmd_core_req_t core_req;
    mmd_prog_t     prog;
    mmd_core_rsp_t core_rsp;
    int            n_errors     = 0;
    int            tests_run    = 0;
    int            cycles       = 0;
    mmd_row_t      rows[$];

    always #20 core_clk = ~core_clk;

    mmd_decoder i_dut (.CORE_CLK(core_clk), .RST(rst), .CORE_REQ(core_req), .PROG(prog),
                       .ROLL_RELEASE(roll_release), .CORE_RSP(core_rsp));
    mmd_core_model i_core (.CORE_CLK(core_clk), .CORE_REQ(core_req), .PROG(prog));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : final_report

    // Data rows keep pc at zero and the stack empty.
    task automatic dw(input mmd_space_t s, input logic [5:0] a, input logic [7:0] wd);
        rows.push_back({1'h0, FL_NEXT, 10'h0, 8'h0, 1'h1, 1'h1, s, a, wd, 10'h0, 8'h0, 2'h0, 4'h0});
    endtask : dw

    task automatic dr(input mmd_space_t s, input logic [5:0] a, input logic [7:0] rd, input logic [1:0] bk);
        rows.push_back({1'h0, FL_NEXT, 10'h0, 8'h0, 1'h1, 1'h0, s, a, 8'h0, 10'h0, rd, bk, 4'h0});
    endtask : dr

    task automatic fr(input mmd_flow_t f, input logic [9:0] t, input logic [7:0] ac, input logic [9:0] pc,
                      input logic [3:0] dep);
        rows.push_back({1'h1, f, t, ac, 1'h0, 1'h0, SP_NONE, 6'h0, 8'h0, pc, 8'h0, 2'h0, dep});
    endtask : fr

    function automatic mmd_core_req_t fl(input mmd_flow_t f, input logic [9:0] t);
        fl = '0;
        fl.step = 1'b1;
        fl.flow = f;
        fl.target = t;
    endfunction : fl

    // A hang is cut short well past the expected 110 or so cycles.
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            n_errors++;
            final_report();
        end
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        mmd_core_req_t r;
        repeat (6) @(negedge core_clk);
        rst = 1'b0;
        dr(SP_R, 6'h3, 8'h18, 2'h0);
        dr(SP_R, 6'h8, 8'h88, 2'h0);
        dr(SP_R, 6'h9, 8'h3f, 2'h0);
        dw(SP_R, 6'h10, 8'h5a);
        dw(SP_R, 6'h4, 8'hc0);
        dr(SP_R, 6'h10, 8'h5a, 2'h3);
        dw(SP_R, 6'h5, 8'hff);
        dr(SP_R, 6'h5, 8'h00, 2'h3);
        dw(SP_F, 6'h6, 8'h33);
        dr(SP_F, 6'h6, 8'h33, 2'h3);
        dr(SP_R, 6'h6, 8'h00, 2'h3);
        dw(SP_S, 6'h36, 8'h77);
        dr(SP_S, 6'h6, 8'h77, 2'h3);
        dw(SP_S, 6'h9, 8'haa);
        dr(SP_S, 6'h9, 8'h00, 2'h3);
        dr(SP_F, 6'h0, 8'h00, 2'h3);
        dw(SP_R, 6'h4, 8'h51);
        dw(SP_R, 6'h0, 8'h9c);
        dr(SP_R, 6'h11, 8'h9c, 2'h1);
        dr(SP_R, 6'h0, 8'h9c, 2'h1);
        dw(SP_R, 6'ha, 8'h02);
        fr(FL_SJMP, 10'h155, 8'h0, 10'h355, 4'h0);
        fr(FL_SCALL, 10'h1c4, 8'h0, 10'h2c4, 4'h1);
        fr(FL_ACALL, 10'h0, 8'h7e, 10'h27e, 4'h2);
        fr(FL_LONG_CALL_INSTR, 10'h123, 8'h0, 10'h123, 4'h3);
        fr(FL_SWI, 10'h0, 8'h0, 10'h001, 4'h4);
        fr(FL_HWI, 10'h0, 8'h0, 10'h008, 4'h5);
        fr(FL_RETI, 10'h0, 8'h0, 10'h002, 4'h4);
        fr(FL_RETL, 10'h0, 8'h0, 10'h124, 4'h3);
        fr(FL_RET, 10'h0, 8'h0, 10'h27f, 4'h2);
        fr(FL_RET, 10'h0, 8'h0, 10'h2c5, 4'h1);
        fr(FL_RET, 10'h0, 8'h0, 10'h356, 4'h0);
        fr(FL_AJMP, 10'h0, 8'h10, 10'h210, 4'h0);
        fr(FL_LJMP, 10'h3fd, 8'h0, 10'h3fd, 4'h0);
        foreach (rows[i])
        begin
            i_core.issue(rows[i].req);
            check("pc", rows[i].pc, core_rsp.pc);
            check("depth", rows[i].dep, core_rsp.depth);
            if (rows[i].req.dvalid && !rows[i].req.dwrite)
            begin
                check("rdata", rows[i].rd, core_rsp.rdata);
                check("bank", rows[i].bk, core_rsp.bank);
            end
        end
        check("rsvd", 16'h0, core_rsp.rsvd_fetch);
        // A low counter byte write jumps inside the high buffer page.
        r = fl(FL_NEXT, 10'h0);
        r.dvalid = 1'b1;
        r.dwrite = 1'b1;
        r.space = SP_R;
        r.addr = 6'h2;
        r.wdata = 8'h40;
        i_core.issue(r);
        check("pc", 10'h240, core_rsp.pc);
        i_core.issue(fl(FL_NEXT, 10'h0));
        check("pc", 10'h241, core_rsp.pc);
        i_core.issue(fl(FL_LJMP, RSVD_FIRST));
        check("rsvd", 16'h1, core_rsp.rsvd_fetch);
        // Rolling code words read preset until released, then hold code.
        i_core.issue(fl(FL_LJMP, ROLL_ADDR0));
        check("instr", ROLL_CODE0, core_rsp.instr);
        i_core.load(ROLL_ADDR1, 14'h0321);
        roll_release = 1'b1;
        i_core.issue(fl(FL_LJMP, ROLL_ADDR1));
        check("instr", 14'h0321, core_rsp.instr);
        // A return right after a call restores the following address.
        i_core.issue2(fl(FL_LONG_CALL_INSTR, 10'h200), fl(FL_RET, 10'h0));
        check("pc", 10'h010, core_rsp.pc);
        check("depth", 4'h0, core_rsp.depth);
        // Nine calls fill the eight levels; depth saturates.
        repeat (9) i_core.issue(fl(FL_LONG_CALL_INSTR, 10'h100));
        check("depth", DEPTH_FULL, core_rsp.depth);
        i_core.issue(fl(FL_RET, 10'h0));
        check("pc", 10'h101, core_rsp.pc);
        check("depth", 4'h7, core_rsp.depth);
        // Reset in mid-run returns fetch to address zero.
        rst = 1'b1;
        @(negedge core_clk);
        check("pc", RESET_VEC, core_rsp.pc);
        check("depth", 4'h0, core_rsp.depth);
        check("rdata", 8'h0, core_rsp.rdata);
        check("bank", 2'h0, core_rsp.bank);
        check("instr", 14'h0, core_rsp.instr);
        rst = 1'b0;
        final_report();
    end
endmodule : mmd_decoder_tb_top
